//--- pkg/sld_pkg.sv
// package of the status led and undervoltage diagnosis block
// assumes a single 100 MHz clock and a synchronous active-high reset
//
// Operation
// - run indicator stays dark in the INIT slave state
// - run indicator blinks at 2 Hz in the PREOP slave state
// - run indicator blinks at 1 Hz in SAFEOP; outputs held safe
// - run indicator lit steadily in the OP slave state
// - run indicator blinks at 10 Hz in the BOOTSTRAP slave state
// - red bus-supply indicator lit while bus supply below 17 V
// - red power-contact indicator lit while contact supply below 17 V
// - two-bit diagnosis field: contact bit and bus-supply bit
// - each diagnosis bit is one while its supply is below 17 V
`default_nettype none
package sld_pkg;

  // ==========================================================
  // clock and blink timing
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned PREOP_HZ   = 2;
  localparam int unsigned SAFEOP_HZ  = 1;
  localparam int unsigned BOOT_HZ    = 10;
  // half period in cycles: equal on and off time
  localparam int unsigned PREOP_HALF  = CLK_HZ / (2 * PREOP_HZ);
  localparam int unsigned SAFEOP_HALF = CLK_HZ / (2 * SAFEOP_HZ);
  localparam int unsigned BOOT_HALF   = CLK_HZ / (2 * BOOT_HZ);

  // ==========================================================
  // register map, byte addresses
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [7:0]  REG_INTSTS = 8'h08;
  localparam logic [7:0]  REG_INTMSK = 8'h0C;

  // field positions
  localparam int          CTRL_STATE_LSB = 0;
  localparam int          STAT_RUN_BIT   = 3;
  localparam int          STAT_CUV_BIT   = 4;
  localparam int          STAT_BUV_BIT   = 5;
  localparam int          STAT_SAFE_BIT  = 6;
  localparam int          INT_CONTACT    = 0;
  localparam int          INT_BUS        = 1;

  // reset values
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [1:0]  INTMSK_RST = 2'h0;

  // ==========================================================
  // slave state machine, software writes the position
  typedef enum logic [2:0] {
    SLD_INIT,
    SLD_PREOP,
    SLD_SAFEOP,
    SLD_OP,
    SLD_BOOT
  } sld_esm_t;

  // diagnosis field of the cyclic input image
  typedef struct packed {
    logic busUv;      // bit 1
    logic contactUv;  // bit 0
  } sld_diag_t;

  // indicator outputs
  typedef struct packed {
    logic run;
    logic busUvRed;
    logic contactUvRed;
  } sld_led_t;

endpackage
`default_nettype wire

//--- hw/sld_blink_div.sv
// free running blink divider: toggles a level every HALF cycles
// assumes mclk and synchronous active-high sys_rst
`timescale 1ns/10ps
`default_nettype none
module sld_blink_div #(
  parameter int unsigned HALF = 4
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  output logic      level
);

  localparam int W = (HALF > 2) ? $clog2(HALF) : 1;
  localparam logic [W-1:0] LAST = W'(HALF - 1);

  logic [W-1:0] cnt;

  // ==========================================================
  // half period counter and toggle, equal on and off time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt   <= '0;
      level <= 1'b0;
    end else if (cnt == LAST) begin
      cnt   <= '0;
      level <= ~level;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // level only moves at the end of a half period
  a_half_even: assert property (@(posedge mclk) disable iff (sys_rst)
    (cnt != LAST) |=> $stable(level))
    else $error("blink level moved inside a half period");

endmodule
`default_nettype wire

//--- hw/sld_status_diag.sv
// status led and undervoltage diagnosis block with apb register slave
// assumes synchronous comparator inputs and an apb master on mclk
`timescale 1ns/10ps
`default_nettype none
module sld_status_diag
  import sld_pkg::*;
#(
  parameter int unsigned PREOP_CNT  = PREOP_HALF,
  parameter int unsigned SAFEOP_CNT = SAFEOP_HALF,
  parameter int unsigned BOOT_CNT   = BOOT_HALF
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // comparator results, high while supply below 17 V
  input  wire logic              busSupplyLow,
  input  wire logic              contactSupplyLow,
  // indicators, process image and control outputs
  output sld_led_t               leds,
  output sld_diag_t              diagImage,
  output logic                   safeHold,
  output logic                   irq
);

  // ==========================================================
  // declarations
  sld_esm_t   esmState;
  logic [1:0] intStat;
  logic [1:0] intMask;
  logic [1:0] next_intStat;
  logic [1:0] chgEvent;
  logic [1:0] clrBits;
  logic [31:0] rdMux;
  logic        rdHit;
  logic        accessPh;
  logic        wrDone;
  logic        blinkPreop;
  logic        blinkSafeop;
  logic        blinkBoot;
  sld_esm_t    wrState;
  logic        wrLegal;
  logic        runLit;
  logic        busRed;
  logic        contactRed;

  // ==========================================================
  // blink generators, one per flashing rate
  sld_blink_div #(.HALF(PREOP_CNT)) uPreop (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .level   (blinkPreop)
  );

  sld_blink_div #(.HALF(SAFEOP_CNT)) uSafeop (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .level   (blinkSafeop)
  );

  sld_blink_div #(.HALF(BOOT_CNT)) uBoot (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .level   (blinkBoot)
  );

  // ==========================================================
  // apb handshake: one wait cycle, write lands with pready high
  assign accessPh = psel & penable;
  assign wrDone   = accessPh & pready & pwrite;

  // pready high for exactly one cycle per access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= accessPh & ~pready;
    end
  end

  // read decode, unmapped addresses read zero with an error
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (paddr)
      REG_CTRL: begin
        rdMux[CTRL_STATE_LSB +: 3] = esmState;
      end
      REG_STATUS: begin
        rdMux[2:0]           = esmState;
        rdMux[STAT_RUN_BIT]  = leds.run;
        rdMux[STAT_CUV_BIT]  = diagImage.contactUv;
        rdMux[STAT_BUV_BIT]  = diagImage.busUv;
        rdMux[STAT_SAFE_BIT] = safeHold;
      end
      REG_INTSTS: begin
        rdMux[1:0] = intStat;
      end
      REG_INTMSK: begin
        rdMux[1:0] = intMask;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // read data and error are registered alongside pready
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (accessPh & ~pready) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr <= ~rdHit;
    end else begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // slave state register, illegal codes leave the state alone
  always_comb begin
    wrState = SLD_INIT;
    wrLegal = 1'b1;
    unique case (pwdata[CTRL_STATE_LSB +: 3])
      3'h0: wrState = SLD_INIT;
      3'h1: wrState = SLD_PREOP;
      3'h2: wrState = SLD_SAFEOP;
      3'h3: wrState = SLD_OP;
      3'h4: wrState = SLD_BOOT;
      default: wrLegal = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      esmState <= SLD_INIT;
    end else if (wrDone && paddr == REG_CTRL && wrLegal) begin
      esmState <= wrState;
    end
  end

  // ==========================================================
  // run indicator pattern per slave state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      runLit <= 1'b0;
    end else begin
      unique case (esmState)
        SLD_INIT:   runLit <= 1'b0;
        SLD_PREOP:  runLit <= blinkPreop;
        SLD_SAFEOP: runLit <= blinkSafeop;
        SLD_OP:     runLit <= 1'b1;
        SLD_BOOT:   runLit <= blinkBoot;
        default:    runLit <= 1'b0;
      endcase
    end
  end

  // outputs kept in safe condition outside OP
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      safeHold <= 1'b1;
    end else begin
      safeHold <= (esmState != SLD_OP);
    end
  end

  // ==========================================================
  // undervoltage indicators and diagnosis field
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busRed     <= 1'b0;
      contactRed <= 1'b0;
    end else begin
      busRed     <= busSupplyLow;
      contactRed <= contactSupplyLow;
    end
  end

  // indicator bundle, one flip-flop behind each field
  assign leds = {runLit, busRed, contactRed};

  // process image: bit 0 contact supply, bit 1 bus supply
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      diagImage <= '0;
    end else begin
      diagImage.contactUv <= contactSupplyLow;
      diagImage.busUv     <= busSupplyLow;
    end
  end

  // ==========================================================
  // interrupts: any change of a diagnosis bit is an event
  assign chgEvent[INT_CONTACT] = diagImage.contactUv ^ contactSupplyLow;
  assign chgEvent[INT_BUS]     = diagImage.busUv ^ busSupplyLow;
  assign clrBits = (wrDone && paddr == REG_INTSTS) ? pwdata[1:0] : 2'h0;
  // a new event wins over a write-one-to-clear
  assign next_intStat = (intStat & ~clrBits) | chgEvent;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intStat <= 2'h0;
    end else begin
      intStat <= next_intStat;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intMask <= INTMSK_RST;
    end else if (wrDone && paddr == REG_INTMSK) begin
      intMask <= pwdata[1:0];
    end
  end

  // level interrupt, follows status one cycle later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat & intMask);
    end
  end

  // ==========================================================
  // assertions
  a_init_dark: assert property (@(posedge mclk) disable iff (sys_rst)
    (esmState == SLD_INIT) ##1 (esmState == SLD_INIT) |-> !leds.run)
    else $error("run indicator lit in INIT");

  a_preop_blink: assert property (@(posedge mclk) disable iff (sys_rst)
    (esmState == SLD_PREOP) |=> (leds.run == $past(blinkPreop)))
    else $error("run indicator not following 2 Hz blink");

  a_safeop_blink: assert property (@(posedge mclk) disable iff (sys_rst)
    (esmState == SLD_SAFEOP) |=> (leds.run == $past(blinkSafeop)) && safeHold)
    else $error("SAFEOP blink or safe hold wrong");

  a_op_lit: assert property (@(posedge mclk) disable iff (sys_rst)
    (esmState == SLD_OP) [*2] |-> leds.run && !safeHold)
    else $error("run indicator not steady in OP");

  a_boot_blink: assert property (@(posedge mclk) disable iff (sys_rst)
    (esmState == SLD_BOOT) |=> (leds.run == $past(blinkBoot)))
    else $error("run indicator not following 10 Hz blink");

  a_bus_red: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && busSupplyLow) ##1 busSupplyLow |-> leds.busUvRed)
    else $error("bus supply red indicator wrong");

  a_contact_red: assert property (@(posedge mclk) disable iff (sys_rst)
    !contactSupplyLow |=> !leds.contactUvRed)
    else $error("contact supply red indicator wrong");

  a_diag_field: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 (diagImage == {leds.busUvRed, leds.contactUvRed}))
    else $error("diagnosis field disagrees with indicators");

  a_diag_value: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && contactSupplyLow) |=> diagImage.contactUv)
    else $error("contact undervoltage bit not set");

  a_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    (|(intStat & intMask)) |=> irq)
    else $error("interrupt missing for unmasked status");

  a_bus_dark: assert property (@(posedge mclk) disable iff (sys_rst)
    !busSupplyLow |=> !leds.busUvRed)
    else $error("bus supply red indicator lit without undervoltage");

  a_contact_lit: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && contactSupplyLow) |=> leds.contactUvRed)
    else $error("contact supply red indicator not lit");

  a_bus_diag: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && busSupplyLow) |=> diagImage.busUv)
    else $error("bus undervoltage bit not set");

  a_event_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    (!sys_rst && chgEvent[INT_BUS]) |=> intStat[INT_BUS])
    else $error("bus change event lost against a clear");

  a_ready_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  c_reach_op:   cover property (@(posedge mclk) esmState == SLD_OP);
  c_reach_boot: cover property (@(posedge mclk) esmState == SLD_BOOT && leds.run);
  c_irq_high:   cover property (@(posedge mclk) irq);
  c_bad_addr:   cover property (@(posedge mclk) pready && pslverr);

endmodule
`default_nettype wire

//--- dv/sld_image_reader.sv
// =====================================================
// model of the fieldbus master reading the diagnosis image
// assumes the image is sampled once per mclk cycle
`timescale 1ns/10ps
`default_nettype none
module sld_image_reader
  import sld_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire sld_diag_t diagImage,
  output sld_diag_t      imageSeen
);
  // capture the two-bit diagnosis field every cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      imageSeen <= '0;
    end else begin
      imageSeen <= diagImage;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_sld_status_diag.sv
// =====================================================
// self-checking bench of the status led and diagnosis block
// assumes shortened blink counts and an apb master on mclk
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin comparisons++; if ((a)!==(b)) begin nErrors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_sld_status_diag
  import sld_pkg::*;
;
  logic              mclk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic              busSupplyLow, contactSupplyLow, safeHold, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, q, r;
  logic [31:0]       seed = 32'h26bd_48d4;
  sld_led_t          leds;
  sld_diag_t         diagImage, imageSeen;
  int                nErrors = 0, comparisons = 0, cyc = 0;
  integer            hi, lo;

  sld_status_diag #(.PREOP_CNT(4), .SAFEOP_CNT(8), .BOOT_CNT(2)) i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busSupplyLow(busSupplyLow), .contactSupplyLow(contactSupplyLow), .leds(leds),
    .diagImage(diagImage), .safeHold(safeHold), .irq(irq));
  sld_image_reader i_rd (.mclk(mclk), .sys_rst(sys_rst), .diagImage(diagImage),
    .imageSeen(imageSeen));

  // =====================================================
  // clock, helpers and apb master
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int half(int s);
    case (s)
      1: return 4;
      2: return 8;
      default: return 2;
    endcase
  endfunction
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  // one transfer: setup, then access held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic closeOut();
    if (nErrors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      nErrors++;
      closeOut();
    end
  end

  // =====================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, busSupplyLow, contactSupplyLow} = '0;
    paddr = '0;
    pwdata = '0;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, REG_STATUS, 0); `CHK(q, 32'h0000_0040)
    apb(1, 8'h10, 0); `CHK(e, 1'b1)
    // every slave state: run pattern, safe hold and readback
    for (int s = 0; s < 5; s++) begin
      apb(1, REG_CTRL, s);
      repeat (3) tick();
      `CHK(safeHold, s != 3)
      hi = 0;
      lo = 0;
      if (s == 0 || s == 3) begin
        repeat (20) begin tick(); hi += leds.run; end
        `CHK(hi, (s == 3) ? 20 : 0)
      end else begin
        while (leds.run !== 1'b0) tick();
        while (leds.run !== 1'b1) tick();
        while (leds.run === 1'b1) begin tick(); hi++; end
        while (leds.run === 1'b0) begin tick(); lo++; end
        `CHK(hi, half(s))
        `CHK(lo, half(s))
      end
      apb(0, REG_STATUS, 0); `CHK(q[2:0], s[2:0])
    end
    // undefined state code leaves the state alone
    apb(1, REG_CTRL, 5);
    apb(0, REG_CTRL, 0); `CHK(q, 32'h0000_0004)
    // interrupt: masked contact event, unmasked bus event, clear
    apb(1, REG_INTMSK, 2);
    @(posedge mclk);
    contactSupplyLow <= 1'b1;
    repeat (3) tick();
    `CHK(irq, 1'b0)
    apb(0, REG_INTSTS, 0); `CHK(q, 32'h0000_0001)
    @(posedge mclk);
    busSupplyLow <= 1'b1;
    repeat (3) tick();
    `CHK(irq, 1'b1)
    apb(1, REG_INTSTS, 3);
    repeat (2) tick();
    `CHK(irq, 1'b0)
    // random supply levels reach leds and image
    repeat (40) begin
      r = rnd();
      @(posedge mclk);
      busSupplyLow <= r[0];
      contactSupplyLow <= r[1];
      repeat (2) tick();
      `CHK(diagImage, {r[0], r[1]})
      `CHK(leds[1:0], {r[0], r[1]})
      `CHK(imageSeen, {r[0], r[1]})
    end
    // mid-run reset puts state, mask and outputs back to reset values
    @(posedge mclk);
    busSupplyLow <= 1'b0;
    contactSupplyLow <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(0, REG_CTRL, 0); `CHK(q, 32'h0000_0000)
    apb(0, REG_INTMSK, 0); `CHK(q, 32'h0000_0000)
    `CHK(irq, 1'b0)
    `CHK(leds, 3'h0)
    closeOut();
  end
endmodule
`default_nettype wire
